// *** trs_ctl.sv ***
// controlling end: reset sequencer driven by software over Avalon-MM
// Operation
// [R1] tx-only: load rate, then pulse commit
// [R2] hold tx digital reset until busy falls
// [R3] controller raises busy on commit
// [R4] controller drops busy when finished
// [R5] channel mode: settings, commit, assert three resets
// [R6] controller flags channel reconfiguration complete
// [R7] release tx reset, wait five cycles
// [R8] after lock, wait 4 us, release rx digital
// [R9] power-down input powers down whole block
// [R10] power-down pulse lasts at least 1 us
// [R11] wait busy low before power-down
// [R12] unused blocks powered down at configuration
// [R13] without power-down, resets driven explicitly
// [R14] power-down held at least one cycle
// [R15] simulation may skip the 4 us wait
// [R16] simulated busy lasts about 20 cycles
// [R17] PCIe simulation: force idle before data
// [R18] commit is one pulse; busy seen first
// [R19] time waits counted, rounded upward
// assumes the device end shares SYS_CLK
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module trs_ctl
  import trs_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_WAIT_CYC,
  parameter int PDN_MIN = PDN_MIN_CYC,
  parameter int GAP = ARST_GAP_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // link
  trs_if.ctl LNK,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  typedef enum {
    S_PDN, S_PDN_HOLD, S_IDLE, S_COMMIT, S_WBUSY, S_WDONE, S_GAP, S_WLOCK, S_LOCKWAIT
  } trs_state_t;
  trs_state_t state_r;
  trs_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [RATE_W-1:0] rate_r;
  logic [MODE_W-1:0] mode_r;
  logic fastsim_r;
  logic chan_r;
  logic seen_busy_r;
  logic req_tx_r;
  logic req_ch_r;
  logic req_pdn_r;
  logic tx_rst_r;
  logic rxa_rst_r;
  logic rxd_rst_r;
  logic pdn_r;
  logic commit_r;
  logic ack_r;
  logic wait_r;
  logic [31:0] rdata_r;
  // bus decode: one wait cycle; a write lands on the edge that sees waitrequest low
  wire bus_req = (AVS_READ || AVS_WRITE) && !ack_r;
  wire wr_ctrl = AVS_WRITE && ack_r && (AVS_ADDRESS == REG_CTRL);
  wire wr_cfg = AVS_WRITE && ack_r && (AVS_ADDRESS == REG_CFG);
  wire idle = (state_r == S_IDLE);
  wire [31:0] stat_word = {22'h0, state_r != S_IDLE, LNK.rx_freq_lock, LNK.chan_done,
    LNK.busy, pdn_r, rxd_rst_r, rxa_rst_r, tx_rst_r, 2'h0};
  wire [31:0] cfg_word = {23'h0, fastsim_r, 1'b0, mode_r, 2'h0, rate_r};
  wire [31:0] ctrl_word = {29'h0, req_pdn_r, req_ch_r, req_tx_r};
  wire [31:0] rd_mux = (AVS_ADDRESS == REG_CTRL) ? ctrl_word :
    (AVS_ADDRESS == REG_STAT) ? stat_word :
    (AVS_ADDRESS == REG_CFG) ? cfg_word : 32'h0;
  wire cnt_hit_lock = fastsim_r || (cnt_r >= CNT_W'(LOCK_WAIT - 1)); // [R15] [R19]
  wire cnt_hit_pdn = cnt_r >= CNT_W'(PDN_MIN - 1); // [R10] [R14] [R19]
  wire cnt_hit_gap = cnt_r >= CNT_W'(GAP - 1);
  wire take_op = idle && (state_nxt == S_COMMIT);
  wire take_pdn = idle && (state_nxt == S_PDN);
  wire arm_rst = (state_nxt == S_PDN_HOLD) || (state_r == S_COMMIT);
  wire arm_rx = (state_r != S_COMMIT) || chan_r;
  wire tx_only_end = (state_r == S_WBUSY) && (state_nxt == S_IDLE);
  wire enter_gap = (state_nxt == S_GAP);
  wire leave_gap = (state_r == S_GAP) && (state_nxt == S_WLOCK);
  wire leave_lock = (state_r == S_LOCKWAIT) && (state_nxt == S_IDLE);
  assign LNK.rate_sel = rate_r;
  assign LNK.mode_sel = mode_r;
  assign LNK.commit = commit_r;
  assign LNK.tx_dig_rst = tx_rst_r;
  assign LNK.rx_ana_rst = rxa_rst_r;
  assign LNK.rx_dig_rst = rxd_rst_r;
  assign LNK.blk_pdn = pdn_r;
  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA = rdata_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_PDN: if (!LNK.busy) state_nxt = S_PDN_HOLD; // [R11]
      S_PDN_HOLD: if (cnt_hit_pdn) state_nxt = S_GAP;
      S_IDLE: begin
        if (req_pdn_r) state_nxt = S_PDN;
        else if (req_tx_r || req_ch_r) state_nxt = S_COMMIT;
      end
      S_COMMIT: state_nxt = S_WBUSY;
      S_WBUSY: if (seen_busy_r && !LNK.busy) state_nxt = chan_r ? S_WDONE : S_IDLE; // [R18]
      S_WDONE: if (LNK.chan_done) state_nxt = S_GAP; // [R7]
      S_GAP: if (cnt_hit_gap) state_nxt = S_WLOCK;
      S_WLOCK: if (LNK.rx_freq_lock) state_nxt = S_LOCKWAIT; // [R8]
      S_LOCKWAIT: if (cnt_hit_lock) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_r <= S_PDN;
      cnt_r <= '0;
      seen_busy_r <= 1'b0;
      chan_r <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : cnt_r + 1'b1;
      if (state_r == S_COMMIT) seen_busy_r <= 1'b0;
      else if (LNK.busy) seen_busy_r <= 1'b1; // [R18]
      if (idle && state_nxt == S_COMMIT) chan_r <= req_ch_r;
    end
  end
  // link outputs, all registered; commit and power-down share one process, each reset has its own
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      commit_r <= 1'b0;
      pdn_r <= 1'b0;
    end else if (CE) begin
      commit_r <= (state_nxt == S_COMMIT); // single pulse after settings [R1] [R5] [R18]
      pdn_r <= (state_nxt == S_PDN_HOLD); // [R9] [R10]
    end
  end
  // transmitter held quiet at least one cycle before data resumes
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      tx_rst_r <= 1'b1;
    end else if (CE) begin
      if (arm_rst) begin
        tx_rst_r <= 1'b1; // [R2] [R13] [R17]
      end else if (tx_only_end) begin
        tx_rst_r <= 1'b0; // released only after busy falls [R2]
      end else if (enter_gap) begin
        tx_rst_r <= 1'b0; // [R7]
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rxa_rst_r <= 1'b1;
    end else if (CE) begin
      if (arm_rst && arm_rx) begin
        rxa_rst_r <= 1'b1; // [R5]
      end else if (leave_gap) begin
        rxa_rst_r <= 1'b0; // after five cycles [R7]
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rxd_rst_r <= 1'b1;
    end else if (CE) begin
      if (arm_rst && arm_rx) begin
        rxd_rst_r <= 1'b1; // [R5]
      end else if (leave_lock) begin
        rxd_rst_r <= 1'b0; // [R8]
      end
    end
  end
  // bus slave; waitrequest is its own flop so the pin leaves a register
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else if (CE) begin
      ack_r <= bus_req;
      wait_r <= !bus_req;
      if (bus_req) rdata_r <= rd_mux;
    end
  end
  // settings are frozen while a sequence runs
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rate_r <= RATE_RST;
      mode_r <= MODE_RST;
      fastsim_r <= 1'b0;
    end else if (CE) begin
      if (wr_cfg && idle) begin
        rate_r <= AVS_WRITEDATA[CFG_RATE_LSB +: RATE_W]; // [R1]
        mode_r <= AVS_WRITEDATA[CFG_MODE_LSB +: MODE_W]; // [R5]
        fastsim_r <= AVS_WRITEDATA[CFG_FASTSIM];
      end
    end
  end
  // request bits clear when the sequencer takes them; a new write wins
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      req_tx_r <= 1'b0;
      req_ch_r <= 1'b0;
      req_pdn_r <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl && AVS_WRITEDATA[CTRL_GO_TX]) req_tx_r <= 1'b1;
      else if (take_op) req_tx_r <= 1'b0;
      if (wr_ctrl && AVS_WRITEDATA[CTRL_GO_CH]) req_ch_r <= 1'b1;
      else if (take_op) req_ch_r <= 1'b0;
      if (wr_ctrl && AVS_WRITEDATA[CTRL_PDN]) req_pdn_r <= 1'b1;
      else if (take_pdn) req_pdn_r <= 1'b0;
    end
  end
endmodule

// *** trs_pkg.sv ***
// package for the reconfiguration reset sequencer: timing counts, modes, field positions
// assumes a single 50 MHz system clock shared by both ends
package trs_pkg;
  localparam int CLK_MHZ = 50;
  localparam int LOCK_WAIT_NS = 4000;
  localparam int LOCK_WAIT_CYC = (LOCK_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PDN_MIN_NS = 1000;
  localparam int PDN_MIN_CYC = (PDN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int ARST_GAP_CYC = 5;
  localparam int BUSY_SIM_CYC = 20;
  localparam int RATE_W = 2;
  localparam int MODE_W = 3;
  localparam int CNT_W = 16;
  // software-visible registers of the controlling end
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h8;
  // control register fields
  localparam int CTRL_GO_TX = 0;
  localparam int CTRL_GO_CH = 1;
  localparam int CTRL_PDN = 2;
  // config register fields
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_FASTSIM = 8;
  localparam logic [RATE_W-1:0] RATE_RST = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CHAN = 3'h1;
endpackage

// *** trs_if.sv ***
// link between the reconfiguration controller end and the reset control end
// assumes both ends share one clock; the bench connects the modports
`timescale 1ns/1ps
interface trs_if;
  import trs_pkg::*;
  logic [RATE_W-1:0] rate_sel;
  logic [MODE_W-1:0] mode_sel;
  logic commit;
  logic busy;
  logic chan_done;
  logic tx_dig_rst;
  logic rx_ana_rst;
  logic rx_dig_rst;
  logic blk_pdn;
  logic rx_freq_lock;
  modport dev (input rate_sel, mode_sel, commit, tx_dig_rst, rx_ana_rst, rx_dig_rst, blk_pdn,
    output busy, chan_done, rx_freq_lock);
  modport ctl (output rate_sel, mode_sel, commit, tx_dig_rst, rx_ana_rst, rx_dig_rst, blk_pdn,
    input busy, chan_done, rx_freq_lock);
endinterface

// *** trs_dev.sv ***
// device end: reconfiguration controller model with block power-down state
// assumes commit is a one-cycle pulse from the controlling end
`timescale 1ns/1ps
module trs_dev
  import trs_pkg::*;
#(
  parameter int BUSY_CYC = BUSY_SIM_CYC,
  parameter int LOCK_CYC = 8
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // link
  trs_if.dev LNK,
  // status toward user side
  output logic [RATE_W-1:0] RATE_ACTIVE,
  output logic [MODE_W-1:0] MODE_ACTIVE,
  output logic POWERED_DOWN
);
  logic [CNT_W-1:0] busy_cnt_r;
  logic [CNT_W-1:0] lock_cnt_r;
  logic busy_r;
  logic done_r;
  logic chan_op_r;
  logic lock_r;
  logic pdn_r;
  logic [RATE_W-1:0] rate_r;
  logic [MODE_W-1:0] mode_r;
  wire start = LNK.commit && !busy_r && !pdn_r;
  wire finish = busy_r && (busy_cnt_r == CNT_W'(BUSY_CYC - 1));
  wire rx_held = LNK.rx_ana_rst || pdn_r;
  assign LNK.busy = busy_r;
  assign LNK.chan_done = done_r;
  assign LNK.rx_freq_lock = lock_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
      done_r <= 1'b0;
      chan_op_r <= 1'b0;
      rate_r <= RATE_RST;
      mode_r <= MODE_RST;
      pdn_r <= 1'b1; // unused block starts powered down, then follows blk_pdn from the first cycle out of reset [R12]
    end else if (CE) begin
      pdn_r <= LNK.blk_pdn; // whole block follows power-down [R9]
      if (start) begin
        busy_r <= 1'b1; // busy rises as soon as commit is seen [R3]
        busy_cnt_r <= '0;
        chan_op_r <= (LNK.mode_sel == MODE_CHAN);
        done_r <= 1'b0;
      end else if (finish) begin
        busy_r <= 1'b0; // busy falls when the operation ends [R4] [R16]
        done_r <= chan_op_r; // channel completion indication [R6]
        rate_r <= LNK.rate_sel;
        mode_r <= LNK.mode_sel;
      end else if (busy_r) begin
        busy_cnt_r <= busy_cnt_r + 1'b1;
      end
    end
  end
  // receiver frequency lock rises a fixed time after analog reset releases
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      lock_cnt_r <= '0;
      lock_r <= 1'b0;
    end else if (CE) begin
      if (rx_held) begin
        lock_cnt_r <= '0;
        lock_r <= 1'b0;
      end else if (lock_cnt_r == CNT_W'(LOCK_CYC)) begin
        lock_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      RATE_ACTIVE <= RATE_RST;
      MODE_ACTIVE <= MODE_RST;
      POWERED_DOWN <= 1'b1;
    end else if (CE) begin
      RATE_ACTIVE <= rate_r;
      MODE_ACTIVE <= mode_r;
      POWERED_DOWN <= pdn_r;
    end
  end
endmodule

// *** trs_asserts.sv ***
// checker on the link between the controlling end and the device end
// assumes one clock; the bench instantiates it beside the link
`timescale 1ns/1ps
module trs_asserts
  import trs_pkg::*;
#(
  parameter int PDN = PDN_MIN_CYC,
  parameter int LOCKW = LOCK_WAIT_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // link
  input wire logic [MODE_W-1:0] mode_sel,
  input wire logic commit,
  input wire logic busy,
  input wire logic chan_done,
  input wire logic tx_dig_rst,
  input wire logic rx_ana_rst,
  input wire logic rx_dig_rst,
  input wire logic blk_pdn,
  input wire logic rx_freq_lock
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_all_rst;
    tx_dig_rst && rx_ana_rst && rx_dig_rst;
  endsequence
  sequence s_busy_run;
    busy [*8] ##[10:14] !busy;
  endsequence
  property p_start; commit && !busy && !blk_pdn |=> busy; endproperty
  property p_end; $rose(busy) |-> s_busy_run; endproperty
  property p_tx_hold; $fell(tx_dig_rst) |-> !busy; endproperty
  property p_pulse; commit |=> !commit; endproperty
  property p_ch_rst; commit && mode_sel == MODE_CHAN |-> ##[0:2] s_all_rst; endproperty
  property p_done; $fell(busy) && mode_sel == MODE_CHAN |-> ##[0:1] chan_done; endproperty
  property p_gap; $fell(rx_ana_rst) |-> $past(!tx_dig_rst, 5); endproperty
  property p_lock; $fell(rx_dig_rst) |-> $past(rx_freq_lock, LOCKW); endproperty
  property p_pdn_w; $fell(blk_pdn) |-> $past(blk_pdn, PDN); endproperty
  property p_pdn_idle; $rose(blk_pdn) |-> !busy; endproperty
  a_start: assert property (p_start) else $error("busy did not follow commit");
  a_end: assert property (p_end) else $error("busy length wrong");
  a_tx_hold: assert property (p_tx_hold) else $error("tx reset dropped while busy");
  a_pulse: assert property (p_pulse) else $error("commit longer than one cycle");
  a_ch_rst: assert property (p_ch_rst) else $error("channel resets missing");
  a_done: assert property (p_done) else $error("channel done missing");
  a_gap: assert property (p_gap) else $error("rx analog released too early");
  a_lock: assert property (p_lock) else $error("rx digital released before lock wait");
  a_pdn_w: assert property (p_pdn_w) else $error("power-down pulse too short");
  a_pdn_idle: assert property (p_pdn_idle) else $error("power-down while busy");
endmodule

// *** trs_tb.sv ***
// self-checking bench: both ends joined by the link, software side over avalon-mm
// assumes one 50 MHz clock; lock wait shortened to keep the run brief
`timescale 1ns/1ps
module trs_tb;
  import trs_pkg::*;
  localparam int LW = 4;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic POWERED_DOWN;
  logic [RATE_W-1:0] RATE_ACTIVE;
  logic [MODE_W-1:0] MODE_ACTIVE;
  logic [31:0] q;
  int err_total = 0;
  int checks = 0;
  trs_if lnk ();
  trs_dev trs_dev_inst (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(1'b1), .LNK(lnk.dev),
    .RATE_ACTIVE(RATE_ACTIVE), .MODE_ACTIVE(MODE_ACTIVE), .POWERED_DOWN(POWERED_DOWN));
  trs_ctl #(.LOCK_WAIT(LW)) trs_ctl_inst (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(1'b1),
    .LNK(lnk.ctl), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));
  trs_asserts #(.LOCKW(LW)) trs_asserts_inst (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
    .mode_sel(lnk.mode_sel), .commit(lnk.commit), .busy(lnk.busy), .chan_done(lnk.chan_done),
    .tx_dig_rst(lnk.tx_dig_rst), .rx_ana_rst(lnk.rx_ana_rst), .rx_dig_rst(lnk.rx_dig_rst),
    .blk_pdn(lnk.blk_pdn), .rx_freq_lock(lnk.rx_freq_lock));
  initial begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    chk("ack", 32'h0, {31'h0, AVS_WAITREQUEST});
    @(posedge SYS_CLK);
  endtask
  // idle means not active, not busy and rx digital reset released
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STAT, 32'h0);
      n++;
    end while ((q[9] !== 1'b0 || q[6] !== 1'b0 || q[4] !== 1'b0) && n < 500);
  endtask
  task automatic t_boot;
    wait_idle;
    chk("stat", 32'h100, q);
    chk("pdown", 32'h0, {31'h0, POWERED_DOWN});
    $display("test boot done");
  endtask
  task automatic t_tx(logic [1:0] r);
    bus(1'b1, REG_CFG, {30'h0, r});
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (3) @(posedge SYS_CLK);
    chk("tx_busy", 32'h3, {30'h0, lnk.tx_dig_rst, lnk.busy});
    bus(1'b1, REG_CFG, 32'h3);
    wait_idle;
    chk("stat", 32'h100, q);
    chk("rate", {30'h0, r}, {30'h0, RATE_ACTIVE});
    bus(1'b0, REG_CFG, 32'h0);
    chk("cfg", {30'h0, r}, q);
    $display("test tx done");
  endtask
  task automatic t_ch;
    bus(1'b1, REG_CFG, 32'h12);
    bus(1'b1, REG_CTRL, 32'h2);
    repeat (3) @(posedge SYS_CLK);
    chk("resets", 32'hF, {28'h0, lnk.tx_dig_rst, lnk.rx_ana_rst, lnk.rx_dig_rst, lnk.busy});
    wait_idle;
    chk("stat", 32'h180, q);
    chk("mode", {29'h0, MODE_CHAN}, {29'h0, MODE_ACTIVE});
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test channel done");
  endtask
  task automatic t_pdn;
    int n;
    n = 0;
    bus(1'b1, REG_CTRL, 32'h4);
    while (POWERED_DOWN !== 1'b1 && n < 20) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("pdown_on", 32'h1, {31'h0, POWERED_DOWN});
    wait_idle;
    chk("stat", 32'h100, q & 32'h37C);
    chk("pdown_off", 32'h0, {31'h0, POWERED_DOWN});
    $display("test power-down done");
  endtask
  initial begin
    #(20 * 40000);
    err_total++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    t_boot;
    for (int r = 1; r < 4; r++) t_tx(r[1:0]);
    t_ch;
    t_pdn;
    test_done;
  end
endmodule
